// ==== logic/dmsdp_top.sv ====
// Data path of a three-mode serial port: stop, UART and 3-wire clocked.
// Assumes synchronous pins and a CPU register port with one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
`include "dmsdp_cfg.svh"
// Summary of operation
// (RULE_01) Three modes: stopped, asynchronous start-bit framed, clocked 3-wire.
// (RULE_02) Stopped mode does no transfer and holds logic idle.
// (RULE_03) UART sends and receives a byte after a start bit, full duplex.
// (RULE_04) UART timing from internal baud divider or divided external clock pin.
// (RULE_05) 3-wire mode moves 8-bit words on clock, data in, data out.
// (RULE_06) 3-wire mode shifts out and in during the same transfer.
// (RULE_07) Software picks MSB-first or LSB-first in 3-wire mode.
// (RULE_08) Transmit data is loaded then shifted out bit by bit.
// (RULE_09) Seven-bit characters send only bits 0 to 6.
// (RULE_10) Writing the transmit register starts the transfer.
// (RULE_11) Transmit register is write-only, 8-bit, reset to all ones.
// (RULE_12) Software must not write the transmit register while busy.
// (RULE_13) Transmit register and receive buffer share one address; reads give buffer.
// (RULE_14) Receive shifter assembles bits and copies each full character to buffer.
// (RULE_15) Receive shifter is not software accessible.
// (RULE_16) Seven-bit received characters fill bits 0 to 6; MSB reads zero.
// (RULE_17) Receive buffer read-only; writes there load the transmit register.
// (RULE_18) Receive buffer is undefined after reset.
// (RULE_19) UART transmit adds start, optional parity and stop bits.
// (RULE_20) UART receive flags parity and other errors in the error register.
// (RULE_21) Parity select: none, zero no check, odd, even.
// (RULE_22) Character length 7 or 8 bits; stop length 1 or 2 bits.
// (RULE_23) Receiver finds falling start edge and samples bit centres.
module dmsdp_top (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Configuration
   input wire dmsdp_pkg::dmsdp_cfg_t cfg_i,
   // Data register port
   input wire logic data_wr_i,
   input wire logic data_rd_i,
   input wire logic [7:0] data_wdata_i,
   output logic [7:0] data_rdata_o,
   // Error register port
   input wire logic err_rd_i,
   output dmsdp_pkg::dmsdp_err_t async_error_reg_o,
   // Status
   output logic tx_busy_o,
   output logic rx_done_o,
   // Pins
   input wire logic async_clock_in_pin_i,
   input wire logic rx_line_pin_i,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   output logic tx_line_pin_o
);
   import dmsdp_pkg::*;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_PAR, TX_STOP} dmsdp_tx_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_TAIL} dmsdp_rx_t;
   typedef struct packed {
      dmsdp_tx_t tx_st;
      logic [7:0] transmit_shift_reg;
      logic [3:0] tx_bits;
      logic [3:0] tx_os;
      logic tx_par;
      logic tx_stop2;
      dmsdp_rx_t rx_st;
      logic [7:0] receive_shift_reg;
      logic [3:0] rx_bits;
      logic [3:0] rx_os;
      logic rx_par;
      logic [7:0] receive_buffer_reg;
      dmsdp_err_t err;
      logic rx_done;
      logic line_q;
      logic sck_q;
      logic sck_out;
      logic tx_out;
      logic tx_busy;
      logic sck_oe;
   } dmsdp_state_t;
   dmsdp_state_t s_reg, s_next;
   logic tick;
   logic uart_on;
   logic csi_on;
   logic [3:0] nbits;
   logic sck_rise;
   logic sck_fall;
   logic out_bit;
   logic in_bit;
   logic par_calc;
   // ****************
   // Baud source
   // ****************
   assign uart_on = (cfg_i.mode == DMSDP_UART); // (RULE_01)
   assign csi_on = (cfg_i.mode == DMSDP_CSI);
   dmsdp_baud_gen u_brg (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .enable_i(uart_on | (csi_on & cfg_i.csi_int_clk)), // (RULE_02)
      .ext_sel_i(uart_on & cfg_i.ext_baud),
      .div_i(cfg_i.baud_div),
      .async_clock_in_pin_i(async_clock_in_pin_i),
      .tick_o(tick)
   );
   // ****************
   // Next state
   // ****************
   always_comb begin
      s_next = s_reg;
      s_next.rx_done = 1'b0;
      s_next.line_q = rx_line_pin_i;
      s_next.sck_q = csi_on ? (cfg_i.csi_int_clk ? s_reg.sck_out : serial_clock_pin_i) : 1'b1;
      nbits = (uart_on && !cfg_i.char_length_sel) ? 4'd7 : 4'd8; // (RULE_22)
      sck_rise = s_next.sck_q & ~s_reg.sck_q;
      sck_fall = ~s_next.sck_q & s_reg.sck_q;
      out_bit = (csi_on && !cfg_i.lsb_first) ? s_reg.transmit_shift_reg[7]
                                             : s_reg.transmit_shift_reg[0]; // (RULE_07)
      in_bit = csi_on ? rx_line_pin_i : s_reg.line_q;
      par_calc = 1'b0;
      if (err_rd_i) begin
         s_next.err = '0;
      end
      if (cfg_i.mode == DMSDP_STOP) begin
         s_next.tx_st = TX_IDLE; // (RULE_02)
         s_next.rx_st = RX_IDLE;
         s_next.tx_out = 1'b1;
         s_next.sck_out = 1'b1;
      end else if (csi_on) begin
         // 3-wire: out on falling, in on rising
         if (s_reg.tx_st == TX_SHIFT && cfg_i.csi_int_clk && tick &&
             !(sck_rise && s_reg.tx_bits == 4'd7)) begin
            s_next.sck_out = ~s_reg.sck_out; // (RULE_05)
         end
         if (s_reg.tx_st == TX_SHIFT && sck_fall) begin
            s_next.tx_out = out_bit; // (RULE_08)
         end
         if (s_reg.tx_st == TX_SHIFT && sck_rise) begin
            s_next.transmit_shift_reg = cfg_i.lsb_first
               ? {in_bit, s_reg.transmit_shift_reg[7:1]}
               : {s_reg.transmit_shift_reg[6:0], in_bit}; // (RULE_06)
            s_next.tx_bits = s_reg.tx_bits + 4'd1;
            if (s_reg.tx_bits == 4'd7) begin
               s_next.tx_st = TX_IDLE;
               s_next.receive_buffer_reg = s_next.transmit_shift_reg; // (RULE_14)
               s_next.rx_done = 1'b1;
            end
         end
      end else begin
         // UART transmitter, 16 ticks a bit
         if (s_reg.tx_st != TX_IDLE && tick) begin
            s_next.tx_os = s_reg.tx_os + 4'd1;
            if (s_reg.tx_os == 4'(`DMSDP_OVERSAMPLE - 1)) begin
               unique case (s_reg.tx_st)
                  TX_SHIFT: begin
                     if (s_reg.tx_bits == nbits) begin
                        if (cfg_i.parity_sel == `DMSDP_PAR_NONE) begin
                           s_next.tx_st = TX_STOP;
                           s_next.tx_out = 1'b1;
                        end else begin
                           s_next.tx_st = TX_PAR; // (RULE_21)
                           unique case (cfg_i.parity_sel)
                              `DMSDP_PAR_ODD: s_next.tx_out = ~s_reg.tx_par;
                              `DMSDP_PAR_EVEN: s_next.tx_out = s_reg.tx_par;
                              default: s_next.tx_out = 1'b0;
                           endcase
                        end
                     end else begin
                        s_next.tx_out = s_reg.transmit_shift_reg[0]; // (RULE_09)
                        s_next.tx_par = s_reg.tx_par ^ s_reg.transmit_shift_reg[0];
                        s_next.transmit_shift_reg = {1'b1, s_reg.transmit_shift_reg[7:1]};
                        s_next.tx_bits = s_reg.tx_bits + 4'd1;
                     end
                  end
                  TX_PAR: begin
                     s_next.tx_st = TX_STOP;
                     s_next.tx_out = 1'b1;
                  end
                  TX_STOP: begin
                     if (cfg_i.stop_length_sel && !s_reg.tx_stop2) begin
                        s_next.tx_stop2 = 1'b1; // (RULE_22)
                     end else begin
                        s_next.tx_st = TX_IDLE;
                     end
                  end
                  default: s_next.tx_st = TX_IDLE;
               endcase
            end
         end
         // UART receiver, runs beside the transmitter
         unique case (s_reg.rx_st) // (RULE_03)
            RX_IDLE: begin
               if (s_reg.line_q && !rx_line_pin_i) begin
                  s_next.rx_st = RX_START; // (RULE_23)
                  s_next.rx_os = 4'd0;
                  s_next.rx_bits = 4'd0;
                  s_next.rx_par = 1'b0;
               end
            end
            RX_START: begin
               if (tick) begin
                  s_next.rx_os = s_reg.rx_os + 4'd1;
                  if (s_reg.rx_os == 4'(`DMSDP_OS_HALF - 1)) begin
                     s_next.rx_os = 4'd0;
                     s_next.rx_st = in_bit ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA, RX_TAIL: begin
               if (tick) begin
                  s_next.rx_os = s_reg.rx_os + 4'd1;
                  if (s_reg.rx_os == 4'(`DMSDP_OVERSAMPLE - 1)) begin // (RULE_23)
                     s_next.rx_bits = s_reg.rx_bits + 4'd1;
                     if (s_reg.rx_st == RX_DATA) begin
                        s_next.receive_shift_reg = (nbits == 4'd7)
                           ? {1'b0, in_bit, s_reg.receive_shift_reg[6:1]}
                           : {in_bit, s_reg.receive_shift_reg[7:1]}; // (RULE_16)
                        s_next.rx_par = s_reg.rx_par ^ in_bit;
                        if (s_reg.rx_bits == nbits - 4'd1) begin
                           s_next.rx_st = RX_TAIL;
                           s_next.rx_bits = 4'd0;
                        end
                     end else if (s_reg.rx_bits == 4'd0 &&
                                  cfg_i.parity_sel[1]) begin
                        // Parity result held, flagged with the stop bit
                        par_calc = s_reg.rx_par ^ in_bit;
                        s_next.rx_par = (par_calc != (cfg_i.parity_sel == `DMSDP_PAR_ODD));
                     end else if (s_reg.rx_bits == 4'd0 &&
                                  cfg_i.parity_sel == `DMSDP_PAR_ZERO) begin
                        s_next.rx_par = s_reg.rx_par;
                     end else begin
                        s_next.rx_st = RX_IDLE;
                        s_next.receive_buffer_reg = s_reg.receive_shift_reg; // (RULE_14)
                        s_next.rx_done = 1'b1;
                        if (!in_bit) begin
                           s_next.err.framing_err = 1'b1; // (RULE_20)
                        end
                        if (s_reg.rx_par && cfg_i.parity_sel[1]) begin
                           s_next.err.parity_err = 1'b1; // (RULE_20)
                        end
                        if (s_reg.rx_done) begin
                           s_next.err.overrun_err = 1'b1;
                        end
                     end
                  end
               end
            end
            default: s_next.rx_st = RX_IDLE;
         endcase
      end
      // Write strobe loads transmit register and, outside stopped mode, starts
      if (data_wr_i) begin // (RULE_17)
         s_next.transmit_shift_reg = data_wdata_i; // (RULE_10)
         if (uart_on || csi_on) begin
            s_next.tx_st = TX_SHIFT;
            s_next.tx_bits = 4'd0;
            s_next.tx_os = 4'd0;
            s_next.tx_par = 1'b0;
            s_next.tx_stop2 = 1'b0;
            if (uart_on) begin
               s_next.tx_out = 1'b0; // (RULE_19)
            end
         end
      end
      s_next.tx_busy = (s_next.tx_st != TX_IDLE);
      s_next.sck_oe = csi_on & cfg_i.csi_int_clk;
   end
   // ****************
   // Registers
   // ****************
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_reg <= '0; // (RULE_18)
         s_reg.transmit_shift_reg <= `DMSDP_TX_RESET; // (RULE_11)
         s_reg.line_q <= 1'b1;
         s_reg.sck_q <= 1'b1;
         s_reg.sck_out <= 1'b1;
         s_reg.tx_out <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
   // ****************
   // Outputs
   // ****************
   assign data_rdata_o = s_reg.receive_buffer_reg; // (RULE_13) (RULE_15)
   assign async_error_reg_o = s_reg.err;
   assign tx_busy_o = s_reg.tx_busy;
   assign rx_done_o = s_reg.rx_done;
   assign serial_clock_pin_o = s_reg.sck_out;
   assign serial_clock_pin_oe_o = s_reg.sck_oe;
   assign tx_line_pin_o = s_reg.tx_out;
endmodule
`default_nettype wire

// ==== logic/dmsdp_cfg.svh ====
// Constants for the dual mode serial data path.
// Assumes inclusion by the package and the top module.
`ifndef DMSDP_CFG_SVH
`define DMSDP_CFG_SVH
`define DMSDP_TX_RESET 8'hFF
`define DMSDP_OVERSAMPLE 16
`define DMSDP_OS_HALF 8
`define DMSDP_PAR_NONE 2'h0
`define DMSDP_PAR_ZERO 2'h1
`define DMSDP_PAR_ODD 2'h2
`define DMSDP_PAR_EVEN 2'h3
`define DMSDP_BRG_RESET 8'h0F
`endif

// ==== logic/dmsdp_pkg.sv ====
// Types shared by the serial data path files.
// Assumes dmsdp_cfg.svh is on the include path.
`include "dmsdp_cfg.svh"
package dmsdp_pkg;
   typedef enum logic [1:0] {DMSDP_STOP, DMSDP_UART, DMSDP_CSI} dmsdp_mode_t;
   typedef struct packed {
      dmsdp_mode_t mode;
      logic [1:0] parity_sel;
      logic char_length_sel;
      logic stop_length_sel;
      logic lsb_first;
      logic csi_int_clk;
      logic ext_baud;
      logic [7:0] baud_div;
   } dmsdp_cfg_t;
   typedef struct packed {
      logic parity_err;
      logic framing_err;
      logic overrun_err;
   } dmsdp_err_t;
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
      logic pin_q;
   } dmsdp_brg_state_t;
endpackage

// ==== logic/dmsdp_baud_gen.sv ====
// Baud tick source: internal divider or divided external clock pin.
// Assumes the pin is synchronous to clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
module dmsdp_baud_gen (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Control
   input wire logic enable_i,
   input wire logic ext_sel_i,
   input wire logic [7:0] div_i,
   input wire logic async_clock_in_pin_i,
   // Tick
   output logic tick_o
);
   import dmsdp_pkg::*;
   dmsdp_brg_state_t st_reg, st_next;
   logic step;
   // ****************
   // Divider
   // ****************
   always_comb begin
      st_next = st_reg;
      st_next.pin_q = async_clock_in_pin_i;
      st_next.tick = 1'b0;
      step = ext_sel_i ? (async_clock_in_pin_i & ~st_reg.pin_q) : 1'b1; // (RULE_04)
      if (!enable_i) begin
         st_next.cnt = 8'h00;
      end else if (step) begin
         if (st_reg.cnt >= div_i) begin
            st_next.cnt = 8'h00;
            st_next.tick = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign tick_o = st_reg.tick;
endmodule
`default_nettype wire

// ==== test/dmsdp_monitor.sv ====
// Checker of the serial data path top module ports.
// Assumes dmsdp_pkg is compiled first; attached by bind below.
`timescale 1ns/100ps
`default_nettype none
// ********************
// Port checker
// ********************
module dmsdp_monitor
   import dmsdp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Watched ports
   input wire dmsdp_pkg::dmsdp_cfg_t cfg_i,
   input wire logic data_wr_i,
   input wire logic err_rd_i,
   input wire logic [7:0] data_rdata_o,
   input wire dmsdp_pkg::dmsdp_err_t async_error_reg_o,
   input wire logic tx_busy_o,
   input wire logic rx_done_o,
   input wire logic serial_clock_pin_o,
   input wire logic tx_line_pin_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   logic uart_int;
   assign uart_int = cfg_i.mode == DMSDP_UART && !cfg_i.ext_baud && cfg_i.baud_div == 8'h00;
   sequence s_start_low;
      !tx_line_pin_o [*8] ##8 !tx_line_pin_o;
   endsequence
   sequence s_stop_high;
      tx_line_pin_o && $past(tx_line_pin_o);
   endsequence
   property p_wr_start;
      data_wr_i && !tx_busy_o && cfg_i.mode != DMSDP_STOP |=> tx_busy_o;
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("write did not start");
   property p_start_bit;
      $rose(tx_busy_o) && uart_int |-> s_start_low;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit too short");
   property p_stop_end;
      $fell(tx_busy_o) && cfg_i.mode == DMSDP_UART |-> s_stop_high;
   endproperty
   a_stop_end: assert property (p_stop_end) else $error("frame end not high");
   property p_stop_idle;
      cfg_i.mode == DMSDP_STOP && !tx_busy_o |=> !tx_busy_o && !rx_done_o;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("activity when stopped");
   property p_rx7_msb;
      rx_done_o && !cfg_i.char_length_sel && cfg_i.mode == DMSDP_UART |=> !data_rdata_o[7];
   endproperty
   a_rx7_msb: assert property (p_rx7_msb) else $error("buffer msb set");
   property p_rdata_hold;
      $changed(data_rdata_o) |-> rx_done_o || $past(rx_done_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("buffer changed");
   property p_err_clear;
      err_rd_i |=> async_error_reg_o == 3'h0 || rx_done_o;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("errors not cleared");
   property p_done_pulse;
      rx_done_o |=> !rx_done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   property p_csi_idle;
      cfg_i.mode == DMSDP_CSI && cfg_i.csi_int_clk && !tx_busy_o ##1 !tx_busy_o
         |-> serial_clock_pin_o;
   endproperty
   a_csi_idle: assert property (p_csi_idle) else $error("clock not idle high");
endmodule
bind dmsdp_top dmsdp_monitor u_mon (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cfg_i(cfg_i),
   .data_wr_i(data_wr_i), .err_rd_i(err_rd_i), .data_rdata_o(data_rdata_o),
   .async_error_reg_o(async_error_reg_o), .tx_busy_o(tx_busy_o), .rx_done_o(rx_done_o),
   .serial_clock_pin_o(serial_clock_pin_o), .tx_line_pin_o(tx_line_pin_o));
`default_nettype wire

// ==== test/dmsdp_peer.sv ====
// Remote peer: UART sender and 3-wire slave.
// Assumes sck_i is the serial clock as it stands on the pin.
`timescale 1ns/100ps
`default_nettype none
// ********************
// Peer model
// ********************
module dmsdp_peer (
   // Clock
   input wire logic clk_sys_i,
   // Control
   input wire logic go_i,
   input wire logic csi_i,
   input wire logic lsb_first_i,
   input wire logic [10:0] frame_i,
   input wire logic [3:0] nbits_i,
   input wire logic [7:0] bitlen_i,
   // Line
   input wire logic sck_i,
   output logic line_o
);
   logic [10:0] sh = 11'h7FF;
   logic [3:0] left = 4'h0;
   logic [7:0] cnt = 8'h00;
   logic [3:0] ci = 4'h0;
   logic sck_q = 1'b1;
   initial line_o = 1'b1;
   always @(posedge clk_sys_i) begin
      sck_q <= sck_i;
      if (go_i) begin
         sh <= frame_i;
         left <= nbits_i;
         cnt <= bitlen_i - 8'h01;
         ci <= 4'h0;
         line_o <= csi_i;
      end else if (csi_i) begin
         if (sck_q && !sck_i && ci < 4'h8) begin
            line_o <= lsb_first_i ? frame_i[ci[2:0]] : frame_i[3'h7 - ci[2:0]];
            ci <= ci + 4'h1;
         end else if (!sck_q && sck_i && ci == 4'h8) begin
            line_o <= ~line_o;
         end
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end else if (left != 4'h0) begin
         line_o <= sh[0];
         sh <= sh >> 1;
         left <= left - 4'h1;
         cnt <= bitlen_i - 8'h01;
      end
   end
endmodule
`default_nettype wire

// ==== test/dmsdp_top_tb.sv ====
// Self-checking bench of the serial data path.
// Assumes the design files, the peer and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
// ********************
// Bench
// ********************
module dmsdp_top_tb;
   import dmsdp_pkg::*;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   dmsdp_cfg_t cfg = '0;
   logic wr = 1'b0, err_rd = 1'b0, go = 1'b0, aclk = 1'b0, csi = 1'b0, lsb = 1'b0;
   logic sck_in = 1'b1;
   logic oe;
   logic [7:0] wdata = 8'h00, bitlen = 8'h10, rdata;
   logic [10:0] frame = 11'h7FF;
   logic [3:0] nbits = 4'h0;
   logic busy, sck_o, tx, line;
   dmsdp_err_t err;
   int fail_count = 0, checks_done = 0;
   always #25 clk_sys_i = ~clk_sys_i;
   always @(negedge clk_sys_i) aclk <= ~aclk;
   dmsdp_top DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cfg_i(cfg), .data_wr_i(wr),
      .data_rd_i(1'b0), .data_wdata_i(wdata), .data_rdata_o(rdata), .err_rd_i(err_rd),
      .async_error_reg_o(err), .tx_busy_o(busy), .rx_done_o(), .async_clock_in_pin_i(aclk),
      .rx_line_pin_i(line), .serial_clock_pin_i(sck_in), .serial_clock_pin_o(sck_o),
      .serial_clock_pin_oe_o(oe), .tx_line_pin_o(tx));
   dmsdp_peer u_peer (.clk_sys_i(clk_sys_i), .go_i(go), .csi_i(csi), .lsb_first_i(lsb),
      .frame_i(frame), .nbits_i(nbits), .bitlen_i(bitlen), .sck_i(sck_o & sck_in),
      .line_o(line));
   task automatic results;
      if (fail_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   function automatic logic pick(input int w);
      return w == 0 ? tx : (w == 1 ? busy : sck_o);
   endfunction
   task automatic wait_for(input int w, input logic v);
      for (int i = 0; i < 5000 && pick(w) !== v; i++) tick(1);
      if (pick(w) !== v) begin
         chk(11'(pick(w)), 11'(v));
         results();
      end
   endtask
   task automatic write(input logic [7:0] d);
      wdata = d;
      wr = 1'b1;
      go = 1'b1;
      tick(1);
      wr = 1'b0;
      go = 1'b0;
   endtask
   // Frame bits after the start bit, sent first at bit 0
   function automatic logic [10:0] mk(input logic [7:0] d, input logic [1:0] p,
         input logic cl, output logic [3:0] k);
      logic [7:0] m;
      m = cl ? d : {1'b0, d[6:0]};
      mk = 11'h7FF;
      k = cl ? 4'h8 : 4'h7;
      for (int i = 0; i < 8; i++) if (i < k) mk[i] = m[i];
      if (p != 2'h0) begin
         mk[k] = (p == 2'h1) ? 1'b0 : ((p == 2'h2) ? ~^m : ^m);
         k++;
      end
   endfunction
   task automatic uart_xfer(input logic [7:0] td, rx, input logic [1:0] p,
         input logic cl, sl, bad, ext, input logic [7:0] div);
      logic [10:0] exp, got;
      logic [3:0] k;
      int bl;
      bl = 16 * (int'(div) + 1) * (ext ? 2 : 1);
      exp = mk(td, p, cl, k);
      frame = mk(rx, p, cl, k) ^ (11'(bad && p != 2'h0) << (cl ? 8 : 7));
      nbits = k + 4'h1 + 4'(sl);
      bitlen = 8'(bl);
      csi = 1'b0;
      got = 11'h7FF;
      cfg = '{DMSDP_UART, p, cl, sl, 1'b0, 1'b0, ext, div};
      tick(2);
      write(td);
      wait_for(0, 1'b0);
      tick(bl / 2);
      chk(11'(tx), 11'h000);
      for (int i = 0; i < nbits; i++) begin
         tick(bl);
         got[i] = tx;
         if (i == nbits - 1) chk(11'(busy), 11'h001);
      end
      chk(got, exp);
      wait_for(1, 1'b0);
      tick(bl);
      chk(11'(rdata), 11'(cl ? rx : {1'b0, rx[6:0]}));
      chk(11'(err), 11'({bad && p[1], 2'b00}));
      err_rd = 1'b1;
      tick(1);
      err_rd = 1'b0;
      tick(1);
      chk(11'(err), 11'h000);
   endtask
   task automatic csi_xfer(input logic [7:0] td, rx, input logic l, e);
      logic [7:0] got;
      cfg = '{DMSDP_CSI, 2'h0, 1'b1, 1'b0, l, !e, 1'b0, 8'h03};
      csi = 1'b1;
      lsb = l;
      frame = {3'h0, rx};
      tick(2);
      write(td);
      for (int i = 0; i < 8; i++) begin
         if (e) begin
            sck_in = 1'b0;
            tick(4);
            sck_in = 1'b1;
            tick(4);
         end else begin
            wait_for(2, 1'b0);
            wait_for(2, 1'b1);
         end
         got[l ? i : 7 - i] = tx;
      end
      chk(11'(got), 11'(td));
      chk(11'(oe), 11'(!e));
      wait_for(1, 1'b0);
      tick(4);
      chk(11'(rdata), 11'(rx));
   endtask
   task automatic stop_mode;
      cfg = '0;
      tick(2);
      write(8'h00);
      tick(40);
      chk(11'({busy, tx, oe}), 11'h002);
   endtask
   initial begin
      tick(16);
      nrst_i = 1'b1;
      tick(1);
      chk(11'({busy, tx, sck_o, err}), 11'h018);
      uart_xfer(8'hA5, 8'h3C, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      for (int p = 1; p < 4; p++) begin
         uart_xfer(8'hD3, 8'h95, 2'(p), 1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
      end
      uart_xfer(8'h0F, 8'hF0, 2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
      uart_xfer(8'h81, 8'h7E, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 8'h01);
      csi_xfer(8'hB2, 8'h4D, 1'b0, 1'b0);
      csi_xfer(8'hB2, 8'h4D, 1'b1, 1'b0);
      csi_xfer(8'h6C, 8'hA3, 1'b0, 1'b1);
      stop_mode();
      results();
   end
endmodule
`default_nettype wire
